/* File: hw/acp_pkg.sv */
// constants and types shared by the control and power switch register block
package acp_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [6:0] ADDR_PSW_LO = 7'h6e;
	localparam logic [6:0] ADDR_PSW_HI = 7'h6f;
	localparam logic [6:0] ADDR_CTRL_LO = 7'h70;
	localparam logic [6:0] ADDR_CTRL_HI = 7'h71;
	localparam logic [6:0] ADDR_SHARED = 7'h04;
	localparam logic [6:0] ADDR_STATUS = 7'h07;
	localparam logic [2:0] ADDR_CHAN_TAG = 3'h1;

	// ----------------------------------------
	// reset values and writable masks
	// ----------------------------------------
	localparam logic [15:0] PSW_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] PSW_MASK = 16'h0003;
	localparam logic [15:0] CTRL_MASK = 16'h00ff;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PSW_SW0_BIT = 0;
	localparam int PSW_SW1_BIT = 1;
	localparam int CTRL_SEL_BIT = 7;
	localparam int CTRL_STAT_BIT = 6;
	localparam int CTRL_STREAM_LSB = 4;
	localparam int CTRL_MODE_LSB = 0;

	// ----------------------------------------
	// streaming field codes and commands
	// ----------------------------------------
	localparam logic [1:0] STREAM_OFF = 2'h0;
	localparam logic [1:0] STREAM_READ = 2'h1;
	localparam logic [1:0] STREAM_XMIT = 2'h2;
	localparam logic [7:0] EXIT_CMD = 8'ha5;

	// ----------------------------------------
	// data store layout
	// ----------------------------------------
	localparam int DATA_W = 24;
	localparam int RAM_ENTRIES = 5;
	localparam logic [2:0] SHARED_ENTRY = 3'h4;
	localparam logic [2:0] XSLOT_STAT0 = 3'h0;
	localparam logic [2:0] XSLOT_DATA0 = 3'h2;
	localparam logic [2:0] XSLOT_LAST = 3'h4;

	typedef enum logic [2:0] {
		PH_IDLE, PH_INSTR, PH_WRITE, PH_READ, PH_STREAM, PH_DEAD
	} acp_phase_e;

endpackage

/* File: hw/acp_spi_byte.sv */
// serial interface byte engine, clock idles high, data sampled on rising edge
`timescale 1ns/1ps
module acp_spi_byte (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// byte side
	input wire logic [7:0] tx_byte,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic frame_start,
	output logic frame_end
);

	logic sclk_d_r;
	logic cs_d_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] tx_sh_r;
	logic rise;
	logic fall;

	// edges only count while selected
	assign rise = sclk & ~sclk_d_r & ~cs_n;
	assign fall = ~sclk & sclk_d_r & ~cs_n;

	// pin history and frame edges
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d_r <= 1'b1;
			cs_d_r <= 1'b1;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
			cs_d_r <= cs_n;
			frame_start <= cs_d_r & ~cs_n;
			frame_end <= ~cs_d_r & cs_n;
			miso_oe <= ~cs_n;
		end
	end

	// receive shifter, a partial byte is dropped at frame end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_r <= 3'h0;
			rx_sh_r <= 8'h00;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (cs_n) begin
				bit_cnt_r <= 3'h0;
			end else if (rise) begin
				rx_sh_r <= {rx_sh_r[6:0], mosi};
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (bit_cnt_r == 3'h7) begin
					rx_valid <= 1'b1;
					rx_byte <= {rx_sh_r[6:0], mosi};
				end
			end
		end
	end

	// transmit shifter, a new byte is taken on the first falling edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_sh_r <= 8'h00;
			miso <= 1'b0;
		end else if (fall) begin
			if (bit_cnt_r == 3'h0) begin
				miso <= tx_byte[7];
				tx_sh_r <= {tx_byte[6:0], 1'b0};
			end else begin
				miso <= tx_sh_r[7];
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
		end
	end

endmodule

/* File: hw/acp_data_ram.sv */
// conversion result store, one word per channel plus a shared word
`timescale 1ns/1ps
module acp_data_ram (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// write port
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [acp_pkg::DATA_W-1:0] wdata,
	// read port
	input wire logic [2:0] raddr,
	output logic [acp_pkg::DATA_W-1:0] rdata
);

	logic [acp_pkg::DATA_W-1:0] mem_r [acp_pkg::RAM_ENTRIES];

	// entries reset so a read before any conversion returns zero
	for (genvar i = 0; i < acp_pkg::RAM_ENTRIES; i++) begin : g_ent
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				mem_r[i] <= '0;
			end else if (we && waddr == 3'(i)) begin
				mem_r[i] <= wdata;
			end
		end
	end

	// registered read, unmapped entries read zero
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (raddr < 3'(acp_pkg::RAM_ENTRIES)) begin
			rdata <= mem_r[raddr];
		end else begin
			rdata <= '0;
		end
	end

endmodule

/* File: hw/acp_ctrl_regs.sv */
// converter control and power switch registers behind the serial port
// Function
// (RL1) bit 0 closes switch from pin zero
// (RL2) bit 1 closes switch from pin one
// (RL3) switch register at 0x6e/0x6f, resets zero
// (RL4) control register at 0x70/0x71, resets zero
// (RL5) control write resets filter and sequencer
// (RL6) select 0 writes per-channel data registers
// (RL7) per-channel: ready after whole sequence
// (RL8) host avoids repeat in per-channel mode
// (RL9) select 1: shared register, ready per channel
// (RL10) shared register overwritten; host reads promptly
// (RL11) shared mode: status readable with data
// (RL12) streaming read: status follows the result
// (RL13) streaming transmit: status is first byte
// (RL14) transmit with checksum repeats status byte
// (RL15) status disabled: no status byte streamed
// (RL16) host keeps select low through status
// (RL17) streaming only in continuous conversion mode; streaming starts whatever mode_sel holds
// (RL18) exit command leaves streaming read mode
// (RL19) reserved bits read zero, ignore writes
`timescale 1ns/1ps
module acp_ctrl_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// conversion results from the filter
	input wire logic conv_done,
	input wire logic conv_last,
	input wire logic [1:0] conv_chan,
	input wire logic [acp_pkg::DATA_W-1:0] conv_data,
	input wire logic crc_enable,
	// converter control
	output logic rdy_n,
	output logic filter_reset,
	output logic [3:0] mode_sel,
	// power switches
	output logic low_side_switch_zero,
	output logic low_side_switch_one,
	// continuous transmit byte stream
	output logic stream_valid,
	output logic [7:0] stream_byte
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	acp_pkg::acp_phase_e phase_r;
	logic [6:0] addr_r;
	logic [15:0] psw_r;
	logic [15:0] ctrl_r;
	logic rdy_n_r;
	logic filter_reset_r;
	logic data_rd_r;
	logic [1:0] last_ch_r;
	logic [7:0] tx_byte_r;
	logic [7:0] tx_nxt;
	logic [7:0] status_w;
	logic xact_r;
	logic [2:0] xslot_r;
	logic [acp_pkg::DATA_W-1:0] cap_r;
	logic [acp_pkg::DATA_W-1:0] rdata;
	logic [2:0] raddr;
	logic [2:0] waddr;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic frame_start;
	logic frame_end;
	logic wr_hit;
	logic ctrl_wr;
	logic stream_exit;
	logic share;
	logic stat_en;
	logic [1:0] stream_sel;
	logic set_rdy;

	assign share = ctrl_r[acp_pkg::CTRL_SEL_BIT];
	assign stat_en = ctrl_r[acp_pkg::CTRL_STAT_BIT];
	assign stream_sel = ctrl_r[acp_pkg::CTRL_STREAM_LSB +: 2];
	assign wr_hit = (phase_r == acp_pkg::PH_WRITE) && rx_valid;
	assign ctrl_wr = wr_hit && (addr_r == acp_pkg::ADDR_CTRL_LO ||
		addr_r == acp_pkg::ADDR_CTRL_HI);
	assign stream_exit = (phase_r == acp_pkg::PH_STREAM) && rx_valid &&
		addr_r == acp_pkg::ADDR_SHARED && rx_byte == acp_pkg::EXIT_CMD;
	assign status_w = {rdy_n_r, 5'h00, last_ch_r};

	// outputs straight from their flops
	assign rdy_n = rdy_n_r;
	assign filter_reset = filter_reset_r;
	assign mode_sel = ctrl_r[acp_pkg::CTRL_MODE_LSB +: 4];
	assign low_side_switch_zero = psw_r[acp_pkg::PSW_SW0_BIT]; // RL1
	assign low_side_switch_one = psw_r[acp_pkg::PSW_SW1_BIT]; // RL2

	// ----------------------------------------
	// serial byte engine and result store
	// ----------------------------------------
	acp_spi_byte u_spi (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.sclk(sclk),
		.cs_n(cs_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe(miso_oe),
		.tx_byte(tx_byte_r),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.frame_start(frame_start),
		.frame_end(frame_end)
	);

	// per-channel entry when not shared, else the common entry
	assign waddr = share ? acp_pkg::SHARED_ENTRY : {1'b0, conv_chan}; // RL6 RL10
	assign raddr = (addr_r[6:4] == acp_pkg::ADDR_CHAN_TAG) ?
		{1'b0, addr_r[3:2]} : acp_pkg::SHARED_ENTRY;

	acp_data_ram u_ram (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.we(conv_done),
		.waddr(waddr),
		.wdata(conv_data),
		.raddr(raddr),
		.rdata(rdata)
	);

	// ----------------------------------------
	// frame sequencing
	// ----------------------------------------
	// a streaming frame needs no instruction byte and starts at the result
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase_r <= acp_pkg::PH_IDLE;
			addr_r <= 7'h00;
		end else if (frame_start) begin
			if (stream_sel == acp_pkg::STREAM_READ && !rdy_n_r) begin
				phase_r <= acp_pkg::PH_STREAM;
				addr_r <= acp_pkg::ADDR_SHARED;
			end else begin
				phase_r <= acp_pkg::PH_INSTR;
			end
		end else if (frame_end) begin
			phase_r <= acp_pkg::PH_IDLE;
		end else if (rx_valid) begin
			case (phase_r)
				acp_pkg::PH_INSTR: begin
					addr_r <= rx_byte[6:0];
					phase_r <= rx_byte[7] ? acp_pkg::PH_READ : acp_pkg::PH_WRITE;
				end
				acp_pkg::PH_STREAM: begin
					if (stream_exit) begin
						phase_r <= acp_pkg::PH_DEAD; // RL18
					end else begin
						addr_r <= addr_r + 7'h01;
					end
				end
				acp_pkg::PH_WRITE, acp_pkg::PH_READ: begin
					addr_r <= addr_r + 7'h01;
				end
				default: begin
					phase_r <= phase_r;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// switch register, reserved bits masked off on write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			psw_r <= acp_pkg::PSW_RESET; // RL3
		end else if (wr_hit && addr_r == acp_pkg::ADDR_PSW_LO) begin
			psw_r[7:0] <= rx_byte & acp_pkg::PSW_MASK[7:0]; // RL19
		end else if (wr_hit && addr_r == acp_pkg::ADDR_PSW_HI) begin
			psw_r[15:8] <= rx_byte & acp_pkg::PSW_MASK[15:8]; // RL19
		end
	end

	// control register; the exit command drops streaming read
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= acp_pkg::CTRL_RESET; // RL4
		end else if (wr_hit && addr_r == acp_pkg::ADDR_CTRL_LO) begin
			ctrl_r[7:0] <= rx_byte & acp_pkg::CTRL_MASK[7:0];
		end else if (wr_hit && addr_r == acp_pkg::ADDR_CTRL_HI) begin
			ctrl_r[15:8] <= rx_byte & acp_pkg::CTRL_MASK[15:8]; // RL19
		end else if (stream_exit) begin
			ctrl_r[acp_pkg::CTRL_STREAM_LSB +: 2] <= acp_pkg::STREAM_OFF; // RL18
		end
	end

	// any byte written to the control register restarts the filter
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			filter_reset_r <= 1'b0;
		end else begin
			filter_reset_r <= ctrl_wr; // RL5
		end
	end

	// ----------------------------------------
	// data ready
	// ----------------------------------------
	// per-channel mode waits for the last channel of the sequence
	assign set_rdy = conv_done && (share || conv_last); // RL7 RL9

	// a new result wins over a release in the same cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdy_n_r <= 1'b1;
		end else if (set_rdy) begin
			rdy_n_r <= 1'b0; // RL7 RL9
		end else if (ctrl_wr || (frame_end && data_rd_r)) begin
			rdy_n_r <= 1'b1; // RL5
		end
	end

	// remembers whether this frame touched the result area
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_rd_r <= 1'b0;
			last_ch_r <= 2'h0;
		end else begin
			if (frame_end || frame_start) begin
				data_rd_r <= 1'b0;
			end else if (rx_valid && addr_r[6:5] == 2'h0 &&
				(phase_r == acp_pkg::PH_READ ||
				phase_r == acp_pkg::PH_STREAM)) begin
				data_rd_r <= 1'b1;
			end
			if (conv_done) begin
				last_ch_r <= conv_chan;
			end
		end
	end

	// ----------------------------------------
	// read byte mux
	// ----------------------------------------
	// result bytes go most significant first
	always_comb begin
		tx_nxt = 8'h00;
		if (phase_r == acp_pkg::PH_READ || phase_r == acp_pkg::PH_STREAM) begin
			if (addr_r == acp_pkg::ADDR_PSW_LO) begin
				tx_nxt = psw_r[7:0];
			end else if (addr_r == acp_pkg::ADDR_PSW_HI) begin
				tx_nxt = psw_r[15:8];
			end else if (addr_r == acp_pkg::ADDR_CTRL_LO) begin
				tx_nxt = ctrl_r[7:0];
			end else if (addr_r == acp_pkg::ADDR_CTRL_HI) begin
				tx_nxt = ctrl_r[15:8];
			end else if (addr_r == acp_pkg::ADDR_STATUS) begin
				// RL11 RL12 RL15
				if (share && (phase_r == acp_pkg::PH_READ || stat_en)) begin
					tx_nxt = status_w;
				end
			end else if ((addr_r[6:2] == acp_pkg::ADDR_SHARED[6:2] ||
				addr_r[6:4] == acp_pkg::ADDR_CHAN_TAG) &&
				addr_r[1:0] != 2'h3) begin
				if (addr_r[1:0] == 2'h0) begin
					tx_nxt = rdata[23:16];
				end else if (addr_r[1:0] == 2'h1) begin
					tx_nxt = rdata[15:8];
				end else begin
					tx_nxt = rdata[7:0];
				end
			end
		end
	end

	// registered so the shifter sees a stable byte
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_byte_r <= 8'h00;
		end else begin
			tx_byte_r <= tx_nxt;
		end
	end

	// ----------------------------------------
	// continuous transmit
	// ----------------------------------------
	// slots: status, repeated status, then three result bytes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			xact_r <= 1'b0;
			xslot_r <= acp_pkg::XSLOT_STAT0;
			cap_r <= '0;
		end else if (ctrl_wr) begin
			xact_r <= 1'b0; // RL5
		end else if (conv_done && stream_sel == acp_pkg::STREAM_XMIT) begin
			xact_r <= 1'b1;
			cap_r <= conv_data;
			// RL13 RL15
			xslot_r <= stat_en ? acp_pkg::XSLOT_STAT0 : acp_pkg::XSLOT_DATA0;
		end else if (xact_r) begin
			if (xslot_r == acp_pkg::XSLOT_LAST) begin
				xact_r <= 1'b0;
			end else if (xslot_r == acp_pkg::XSLOT_STAT0 && !crc_enable) begin
				xslot_r <= acp_pkg::XSLOT_DATA0;
			end else begin
				xslot_r <= xslot_r + 3'h1; // RL14
			end
		end
	end

	// one byte per clock while a transmission runs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stream_valid <= 1'b0;
			stream_byte <= 8'h00;
		end else begin
			stream_valid <= xact_r && !ctrl_wr;
			if (xslot_r < acp_pkg::XSLOT_DATA0) begin
				stream_byte <= status_w; // RL13 RL14
			end else if (xslot_r == acp_pkg::XSLOT_DATA0) begin
				stream_byte <= cap_r[23:16];
			end else if (xslot_r == acp_pkg::XSLOT_LAST) begin
				stream_byte <= cap_r[7:0];
			end else begin
				stream_byte <= cap_r[15:8];
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_switch_zero_follows: assert property ( // RL1
		(wr_hit && addr_r == acp_pkg::ADDR_PSW_LO)
		|=> low_side_switch_zero == $past(rx_byte[0])
	) else $error("switch zero does not follow written bit");

	a_switch_one_follows: assert property ( // RL2
		(wr_hit && addr_r == acp_pkg::ADDR_PSW_LO)
		|=> low_side_switch_one == $past(rx_byte[1])
	) else $error("switch one does not follow written bit");

	a_reset_values_zero: assert property ( // RL3
		$rose(nrst) |-> psw_r == 16'h0000 && ctrl_r == 16'h0000
	) else $error("registers not zero after reset");

	a_reserved_read_zero: assert property ( // RL19
		psw_r[15:2] == 14'h0000 && ctrl_r[15:8] == 8'h00
	) else $error("reserved bits not zero");

	a_ctrl_write_resets: assert property ( // RL5
		ctrl_wr && !conv_done |=> filter_reset && rdy_n && !xact_r
	) else $error("control write did not reset filter and sequencer");

	a_rdy_waits_sequence: assert property ( // RL7
		(conv_done && !share && !conv_last && rdy_n_r) |=> rdy_n
	) else $error("ready raised before sequence end");

	a_rdy_each_shared: assert property ( // RL9
		(conv_done && share) |=> !rdy_n
	) else $error("ready missing after shared conversion");

	a_status_first_xmit: assert property ( // RL13
		(conv_done && !ctrl_wr && stream_sel == acp_pkg::STREAM_XMIT &&
		stat_en) |-> ##2 stream_valid && stream_byte[1:0] == $past(conv_chan, 2)
	) else $error("status byte not first in transmit");

	a_status_repeat_crc: assert property ( // RL14
		(conv_done && !ctrl_wr && stream_sel == acp_pkg::STREAM_XMIT &&
		stat_en && crc_enable) ##1 !conv_done && !ctrl_wr
		|-> ##2 stream_valid && stream_byte == $past(stream_byte)
	) else $error("status byte not repeated with checksum");

	a_no_status_xmit: assert property ( // RL15
		(conv_done && !ctrl_wr && stream_sel == acp_pkg::STREAM_XMIT &&
		!stat_en) |-> ##2 stream_valid &&
		stream_byte == $past(conv_data[23:16], 2)
	) else $error("status byte sent while disabled");

	a_exit_stream_read: assert property ( // RL18
		stream_exit |=> stream_sel == acp_pkg::STREAM_OFF &&
		phase_r == acp_pkg::PH_DEAD
	) else $error("exit command did not leave streaming read");

	c_ctrl_write: cover property (ctrl_wr);
	c_stream_frame: cover property (
		frame_start && stream_sel == acp_pkg::STREAM_READ
	);
	c_xmit_done: cover property (xact_r && xslot_r == acp_pkg::XSLOT_LAST);
	c_switch_on: cover property ($rose(low_side_switch_one));

endmodule

/* File: tb/acp_host_model.sv */
// host side serial master model for the register block
`timescale 1ns/1ps
module acp_host_model (
	// clock
	input wire logic ref_clk,
	// serial pins
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// ------------------------------------
	// idle levels, clock parked high
	// ------------------------------------
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// select, then give the device setup time
	task automatic open_frame();
		@(negedge ref_clk);
		cs_n = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask

	// one byte msb first, miso taken as sclk rises
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			mosi = tx[i];
			repeat (6) @(negedge ref_clk);
			rx[i] = miso;
			sclk = 1'b1;
			repeat (6) @(negedge ref_clk);
		end
	endtask

	// select dropped only after the last whole byte
	task automatic close_frame();
		cs_n = 1'b1;
		mosi = ~mosi; // released line shows no stale bit
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

/* File: tb/acp_ctrl_regs_tb_top.sv */
// self-checking bench for the control and power switch registers
`timescale 1ns/1ps
module acp_ctrl_regs_tb_top;
	localparam logic [6:0] A_PSW = acp_pkg::ADDR_PSW_LO;
	localparam logic [6:0] A_CTL = acp_pkg::ADDR_CTRL_LO;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, cs_n, mosi, miso, miso_oe;
	logic conv_done = 1'b0;
	logic conv_last = 1'b0;
	logic crc_enable = 1'b0;
	logic [1:0] conv_chan = 2'h0;
	logic [23:0] conv_data = 24'h000000;
	logic rdy_n, filter_reset, sw0, sw1, stream_valid;
	logic [3:0] mode_sel;
	logic [7:0] stream_byte;
	logic [15:0] rw;
	logic [31:0] d;
	logic [39:0] e;
	logic [7:0] sq[$];
	int mismatches = 0;
	int n_compared = 0;
	int n_frst = 0;
	int k, n;

	// ------------------------------------
	// clock, instances, monitors
	// ------------------------------------
	always #12.5 ref_clk = ~ref_clk;

	acp_ctrl_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.conv_done(conv_done), .conv_last(conv_last),
		.conv_chan(conv_chan), .conv_data(conv_data),
		.crc_enable(crc_enable), .rdy_n(rdy_n),
		.filter_reset(filter_reset), .mode_sel(mode_sel),
		.low_side_switch_zero(sw0), .low_side_switch_one(sw1),
		.stream_valid(stream_valid), .stream_byte(stream_byte));

	acp_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso));

	// pulses are one cycle, so count them at every edge
	always @(posedge ref_clk) begin
		if (filter_reset === 1'b1)
			n_frst <= n_frst + 1;
		if (stream_valid === 1'b1)
			sq.push_back(stream_byte);
	end

	// hang guard, well above the expected run length
	initial begin
		repeat (60000) @(posedge ref_clk);
		$display("[ERR] run_time expected done seen timeout");
		mismatches++;
		report_and_stop();
	end

	// ------------------------------------
	// compare, access and stimulus tasks
	// ------------------------------------
	task automatic chk_word(input string w, input logic [23:0] x,
		input logic [23:0] g);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", w, x, g);
		end
	endtask

	task automatic chk_bit(input string w, input logic x, input logic g);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", w, x, g);
		end
	endtask

	task automatic wr16(input logic [6:0] a, input logic [15:0] v);
		logic [7:0] x;
		host.open_frame();
		host.xbyte({1'b0, a}, x);
		host.xbyte(v[7:0], x);
		host.xbyte(v[15:8], x);
		host.close_frame();
	endtask

	task automatic rd16(input logic [6:0] a, output logic [15:0] v);
		logic [7:0] lo, hi;
		host.open_frame();
		host.xbyte({1'b1, a}, lo);
		host.xbyte(8'h00, lo);
		host.xbyte(8'h00, hi);
		host.close_frame();
		v = {hi, lo};
	endtask

	// four bytes; a streaming frame carries no instruction
	task automatic rd32(input logic [6:0] a, input logic stream,
		output logic [31:0] v);
		logic [7:0] x;
		host.open_frame();
		if (!stream)
			host.xbyte({1'b1, a}, x);
		for (int i = 0; i < 4; i++) begin
			host.xbyte(8'h00, x);
			v = {v[23:0], x};
		end
		host.close_frame();
	endtask

	task automatic conv(input logic [1:0] ch, input logic last,
		input logic [23:0] v);
		@(negedge ref_clk);
		conv_done = 1'b1;
		conv_chan = ch;
		conv_last = last;
		conv_data = v;
		@(negedge ref_clk);
		conv_done = 1'b0;
		repeat (8) @(negedge ref_clk);
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ------------------------------------
	// test sequence
	// ------------------------------------
	initial begin
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (2) @(negedge ref_clk);
		// reset state
		chk_bit("sw0", 1'b0, sw0);
		chk_bit("sw1", 1'b0, sw1);
		chk_bit("miso_oe", 1'b0, miso_oe);
		rd16(A_PSW, rw);
		chk_word("psw", 24'h0, {8'h00, rw});
		rd16(A_CTL, rw);
		chk_word("ctrl", 24'h0, {8'h00, rw});
		$display("test reset done");
		// every switch pattern, reserved bits set on write
		for (int v = 0; v < 4; v++) begin
			wr16(A_PSW, 16'hfffc | 16'(v));
			chk_bit("sw0", v[0], sw0);
			chk_bit("sw1", v[1], sw1);
			rd16(A_PSW, rw);
			chk_word("psw", 24'(v), {8'h00, rw});
		end
		rd16(7'h60, rw);
		chk_word("unmapped", 24'h0, {8'h00, rw});
		$display("test switches done");
		// control write pulses the filter reset per byte
		k = n_frst;
		wr16(A_CTL, 16'hff05);
		chk_word("frst", 24'd2, 24'(n_frst - k));
		rd16(A_CTL, rw);
		chk_word("ctrl", 24'h5, {8'h00, rw});
		chk_word("mode", 24'h5, {20'h0, mode_sel});
		$display("test control done");
		// per-channel results, one ready per sequence
		wr16(A_CTL, 16'h0000);
		conv(2'h0, 1'b0, 24'h123456);
		chk_bit("rdy_n", 1'b1, rdy_n);
		conv(2'h1, 1'b1, 24'habcdef);
		chk_bit("rdy_n", 1'b0, rdy_n);
		rd32(7'h10, 1'b0, d);
		chk_word("ch0", 24'h123456, d[31:8]);
		rd32(7'h14, 1'b0, d);
		chk_word("ch1", 24'habcdef, d[31:8]);
		chk_bit("rdy_n", 1'b1, rdy_n);
		$display("test per_channel done");
		// shared register, newest result wins, status follows
		wr16(A_CTL, 16'h0080);
		conv(2'h2, 1'b0, 24'h111111);
		chk_bit("rdy_n", 1'b0, rdy_n);
		conv(2'h3, 1'b0, 24'h222222);
		rd32(acp_pkg::ADDR_SHARED, 1'b0, d);
		chk_word("shared", 24'h222222, d[31:8]);
		chk_word("status", 24'h03, {16'h0, d[7:0]});
		$display("test shared done");
		// streaming read in continuous mode, then leave it
		wr16(A_CTL, 16'h00d0);
		conv(2'h1, 1'b0, 24'h345678);
		rd32(7'h00, 1'b1, d);
		chk_word("sread", 24'h345678, d[31:8]);
		chk_word("sstat", 24'h01, {16'h0, d[7:0]});
		conv(2'h2, 1'b0, 24'h456789);
		k = n_frst;
		host.open_frame();
		chk_bit("miso_oe", 1'b1, miso_oe);
		host.xbyte(acp_pkg::EXIT_CMD, d[7:0]);
		host.close_frame();
		chk_word("frst", 24'd0, 24'(n_frst - k));
		rd16(A_CTL, rw);
		chk_word("ctrl", 24'hc0, {8'h00, rw});
		$display("test stream_read done");
		// transmit: status twice, once, not at all
		for (int c = 0; c < 3; c++) begin
			crc_enable = (c != 1);
			wr16(A_CTL, (c == 2) ? 16'h00a0 : 16'h00e0);
			sq.delete();
			conv(2'(c), 1'b0, 24'h9abcde);
			n = 5 - c;
			e = {6'h0, 2'(c), 6'h0, 2'(c), 24'h9abcde};
			chk_word("slen", 24'(n), 24'(sq.size()));
			for (int i = 0; i < n && i < sq.size(); i++) begin
				chk_word("sbyte", {16'h0, e[8*(n-1-i) +: 8]},
					{16'h0, sq[i]});
			end
		end
		$display("test stream_xmit done");
		report_and_stop();
	end
endmodule
